/* File: src/rtcf_cfg.svh */
// constants for the reset time-out and reset-cause block
// assumes a 100 MHz core clock and 8-bit register data
`ifndef RTCF_CFG_SVH
`define RTCF_CFG_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RTCF_CLK_NS 10
`define RTCF_POWER_UP_DELAY_TIMER_NS 66000000
`define RTCF_POWER_UP_DELAY_TIMER_CYC ((`RTCF_POWER_UP_DELAY_TIMER_NS + `RTCF_CLK_NS - 1) / `RTCF_CLK_NS)
`define RTCF_PLL_NS 2000000
`define RTCF_PLL_CYC ((`RTCF_PLL_NS + `RTCF_CLK_NS - 1) / `RTCF_CLK_NS)
`define RTCF_OST_LAST 23'h0003FF
`define RTCF_CNT_W 23

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define RTCF_ADDR_RESET_CAUSE_CONTROL 8'h00
`define RTCF_ADDR_STK 8'h01
`define RTCF_ADDR_CFG_BOPU 8'h02
`define RTCF_ADDR_CFG_WDT 8'h03
`define RTCF_ADDR_CFG_PIN 8'h04
`define RTCF_ADDR_CFG_DBG 8'h05

// ----------------------------------------------------------------
// field positions, masks and vectors
// ----------------------------------------------------------------
`define RTCF_RC_IRQ_PRIO 7
`define RTCF_RC_SOFT_BO 6
`define RTCF_RC_INSTR_N 4
`define RTCF_RC_WDT_N 3
`define RTCF_RC_PDOWN_N 2
`define RTCF_RC_PWRON_N 1
`define RTCF_RC_BROWN_N 0
`define RTCF_RC_SW_MASK 8'hD3
`define RTCF_RC_RD_MASK 8'hDF
`define RTCF_RC_RESET 8'h5C
`define RTCF_STK_FULL 7
`define RTCF_STK_UNDER 6
`define RTCF_STK_PTR_MSB 4
`define RTCF_STK_RD_MASK 8'hDF
`define RTCF_BOPU_MASK 8'h1F
`define RTCF_WDT_MASK 8'h3F
`define RTCF_PIN_MASK 8'hBF
`define RTCF_DBG_MASK 8'hC5
`define RTCF_BOEN_LSB 1
`define RTCF_BOEN_SOFT 2'h1
`define RTCF_PUD_EN_N 0
`define RTCF_PIN_RST_EN 7
`define RTCF_DBG_STK_RST 0
`define RTCF_VEC_RESET 21'h000000
`define RTCF_VEC_IRQ_HI 21'h000008
`define RTCF_VEC_IRQ_LO 21'h000018
`define RTCF_PC_STEP 21'h000002

`endif

/* File: src/rtcf_pkg.sv */
// types of the reset time-out and reset-cause block
// assumes rtcf_cfg.svh for widths
`default_nettype none
`include "rtcf_cfg.svh"

package rtcf_pkg;

  // ----------------------------------------------------------------
  // modes and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {rtcf_pm_full, rtcf_pm_run, rtcf_pm_idle, rtcf_pm_sleep} rtcf_pm_t;

  typedef enum logic [3:0] {
    rtcf_osc_low_power_crystal, rtcf_osc_standard_crystal, rtcf_osc_high_speed_crystal,
    rtcf_osc_fast_crystal_with_pll, rtcf_osc_external_clock_input,
    rtcf_osc_external_clock_with_io, rtcf_osc_resistor_capacitor_osc,
    rtcf_osc_resistor_capacitor_osc_io, rtcf_osc_internal_osc_clkout, rtcf_osc_internal_osc_io
  } rtcf_osc_t;

  typedef enum logic [2:0] {rtcf_seq_start, rtcf_seq_pud, rtcf_seq_settle, rtcf_seq_pll,
                            rtcf_seq_done} rtcf_seq_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } rtcf_bus_t;

  typedef struct packed {
    logic [7:0] bopu;
    logic [7:0] wdt;
    logic [7:0] pin;
    logic [7:0] dbg;
  } rtcf_cfg_t;

  typedef struct packed {
    rtcf_seq_t seq;
    logic [`RTCF_CNT_W-1:0] cnt;
    logic osc_prev;
    logic ext_prev;
    logic brown_prev;
    logic [7:0] reset_cause_control;
    logic [7:0] stk;
    logic hold;
    logic vec_load;
    logic [20:0] vec_addr;
    logic [7:0] rdata;
  } rtcf_state_t;

endpackage

`default_nettype wire

/* File: src/rtcf_top.sv */
// reset time-out sequencer and reset-cause flags
// assumes all inputs synchronous to clk_i; srst_i is the power-on pulse
`timescale 1ns/1ns
`default_nettype none
`include "rtcf_cfg.svh"

module rtcf_top #(
  parameter int unsigned POWER_UP_DELAY_TIMER_CYCLES = `RTCF_POWER_UP_DELAY_TIMER_CYC,
  parameter int unsigned PLL_CYCLES = `RTCF_PLL_CYC
) (
  // clock and power-on pulse
  input wire logic clk_i,
  input wire logic srst_i,
  // register port
  input wire rtcf_pkg::rtcf_bus_t bus_i,
  output logic [7:0] rdata_o,
  // configuration fuses
  input wire rtcf_pkg::rtcf_cfg_t cfg_i,
  input wire rtcf_pkg::rtcf_osc_t osc_mode_i,
  // pins and analog events
  input wire logic oscillator_input_pin_i,
  input wire logic external_reset_n_i,
  input wire logic brownout_i,
  // core events
  input wire rtcf_pkg::rtcf_pm_t pm_mode_i,
  input wire logic pm_exit_osc_stopped_i,
  input wire logic reset_instr_i,
  input wire logic wdt_timeout_i,
  input wire logic wake_irq_i,
  input wire logic wake_irq_low_i,
  input wire logic global_irq_enable_high_i,
  input wire logic global_irq_enable_low_i,
  input wire logic stack_full_i,
  input wire logic stack_underflow_i,
  input wire logic [20:0] pc_i,
  // core control
  output logic core_hold_o,
  output logic vec_load_o,
  output logic [20:0] vec_addr_o,
  output logic soft_brownout_enable_o
);

  // ----------------------------------------------------------------
  // state and decoded inputs
  // ----------------------------------------------------------------
  rtcf_pkg::rtcf_state_t state_q;
  rtcf_pkg::rtcf_state_t state_d;
  logic crystal;
  logic with_pll;
  logic pud_en;
  logic pin_en;
  logic stk_rst_en;
  logic soft_bo_mode;
  logic osc_rise;
  logic ext_evt;
  logic brown_evt;
  logic wdt_wake;
  logic irq_wake;

  // settle count applies to the crystal modes only
  assign crystal = (osc_mode_i == rtcf_pkg::rtcf_osc_low_power_crystal) ||
                   (osc_mode_i == rtcf_pkg::rtcf_osc_standard_crystal) ||
                   (osc_mode_i == rtcf_pkg::rtcf_osc_high_speed_crystal) ||
                   (osc_mode_i == rtcf_pkg::rtcf_osc_fast_crystal_with_pll);
  assign with_pll = (osc_mode_i == rtcf_pkg::rtcf_osc_fast_crystal_with_pll);
  assign pud_en = !cfg_i.bopu[`RTCF_PUD_EN_N];
  assign pin_en = cfg_i.pin[`RTCF_PIN_RST_EN];
  assign stk_rst_en = cfg_i.dbg[`RTCF_DBG_STK_RST];
  assign soft_bo_mode = (cfg_i.bopu[`RTCF_BOEN_LSB+1:`RTCF_BOEN_LSB] == `RTCF_BOEN_SOFT);

  // event edges from the registered copies, and wake qualifiers from the power mode
  assign osc_rise = oscillator_input_pin_i && !state_q.osc_prev;
  assign ext_evt = pin_en && state_q.ext_prev && !external_reset_n_i;
  assign brown_evt = brownout_i && !state_q.brown_prev;
  assign wdt_wake = wdt_timeout_i && ((pm_mode_i == rtcf_pkg::rtcf_pm_idle) ||
                                      (pm_mode_i == rtcf_pkg::rtcf_pm_sleep));
  assign irq_wake = wake_irq_i && (pm_mode_i != rtcf_pkg::rtcf_pm_full);

  // masked read of a fuse byte or flag register
  function automatic logic [7:0] rd_masked(input logic [7:0] v, input logic [7:0] m);
    rd_masked = v & m;
  endfunction

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    state_d.osc_prev = oscillator_input_pin_i;
    state_d.ext_prev = external_reset_n_i;
    state_d.brown_prev = brownout_i;
    state_d.vec_load = 1'b0;
    state_d.rdata = 8'h00;

    // time-out sequencer, restarted by the power-on pulse, brown-out and crystal-mode exits that stopped the oscillator
    case (state_q.seq)
      rtcf_pkg::rtcf_seq_start: begin
        state_d.cnt = '0;
        if (brownout_i) begin
          state_d.seq = rtcf_pkg::rtcf_seq_start;
        end else if (pud_en) begin
          state_d.seq = rtcf_pkg::rtcf_seq_pud;
        end else if (crystal) begin
          state_d.seq = rtcf_pkg::rtcf_seq_settle;
        end else begin
          state_d.seq = rtcf_pkg::rtcf_seq_done;
        end
      end
      rtcf_pkg::rtcf_seq_pud: begin
        state_d.cnt = state_q.cnt + 1'b1;
        if (state_q.cnt == `RTCF_CNT_W'(POWER_UP_DELAY_TIMER_CYCLES - 1)) begin
          state_d.cnt = '0;
          if (crystal) begin
            state_d.seq = rtcf_pkg::rtcf_seq_settle;
          end else begin
            state_d.seq = rtcf_pkg::rtcf_seq_done;
          end
        end
      end
      rtcf_pkg::rtcf_seq_settle: begin
        if (osc_rise) begin
          state_d.cnt = state_q.cnt + 1'b1;
          if (state_q.cnt == `RTCF_OST_LAST) begin
            state_d.cnt = '0;
            if (with_pll) begin
              state_d.seq = rtcf_pkg::rtcf_seq_pll;
            end else begin
              state_d.seq = rtcf_pkg::rtcf_seq_done;
            end
          end
        end
      end
      rtcf_pkg::rtcf_seq_pll: begin
        state_d.cnt = state_q.cnt + 1'b1;
        if (state_q.cnt == `RTCF_CNT_W'(PLL_CYCLES - 1)) begin
          state_d.cnt = '0;
          state_d.seq = rtcf_pkg::rtcf_seq_done;
        end
      end
      default: begin
        // leaving a mode that stopped the oscillator re-runs the settle count
        if (pm_exit_osc_stopped_i && crystal) begin
          state_d.cnt = '0;
          state_d.seq = rtcf_pkg::rtcf_seq_settle;
        end
      end
    endcase
    if (brownout_i) begin
      state_d.seq = rtcf_pkg::rtcf_seq_start;
      state_d.cnt = '0;
    end

    // software writes first, so hardware events below win the same cycle
    if (bus_i.we) begin
      if (bus_i.addr == `RTCF_ADDR_RESET_CAUSE_CONTROL) begin
        state_d.reset_cause_control = (state_q.reset_cause_control & ~`RTCF_RC_SW_MASK) | (bus_i.wdata & `RTCF_RC_SW_MASK);
      end else if (bus_i.addr == `RTCF_ADDR_STK) begin
        state_d.stk = bus_i.wdata & `RTCF_STK_RD_MASK;
      end
    end

    // reset instruction clears its own flag only
    if (reset_instr_i) begin
      state_d.reset_cause_control[`RTCF_RC_INSTR_N] = 1'b0;
      state_d.vec_load = 1'b1;
      state_d.vec_addr = `RTCF_VEC_RESET;
    end
    // brown-out: power-on flag untouched
    if (brown_evt) begin
      state_d.reset_cause_control[`RTCF_RC_INSTR_N] = 1'b1;
      state_d.reset_cause_control[`RTCF_RC_WDT_N] = 1'b1;
      state_d.reset_cause_control[`RTCF_RC_PDOWN_N] = 1'b1;
      state_d.reset_cause_control[`RTCF_RC_BROWN_N] = 1'b0;
      state_d.vec_load = 1'b1;
      state_d.vec_addr = `RTCF_VEC_RESET;
    end
    // external reset pin, flags depend on power mode
    if (ext_evt) begin
      state_d.vec_load = 1'b1;
      state_d.vec_addr = `RTCF_VEC_RESET;
      if (pm_mode_i != rtcf_pkg::rtcf_pm_full) begin
        state_d.reset_cause_control[`RTCF_RC_WDT_N] = 1'b1;
      end
      if ((pm_mode_i == rtcf_pkg::rtcf_pm_idle) || (pm_mode_i == rtcf_pkg::rtcf_pm_sleep)) begin
        state_d.reset_cause_control[`RTCF_RC_PDOWN_N] = 1'b0;
      end
    end
    // watchdog: reset when running, wake when idle or asleep
    if (wdt_timeout_i) begin
      state_d.reset_cause_control[`RTCF_RC_WDT_N] = 1'b0;
      state_d.vec_load = 1'b1;
      if (wdt_wake) begin
        state_d.reset_cause_control[`RTCF_RC_PDOWN_N] = 1'b0;
        state_d.vec_addr = pc_i + `RTCF_PC_STEP;
      end else begin
        state_d.vec_addr = `RTCF_VEC_RESET;
      end
    end
    // interrupt wake from a power-managed mode
    if (irq_wake) begin
      state_d.reset_cause_control[`RTCF_RC_PDOWN_N] = 1'b0;
      state_d.vec_load = 1'b1;
      if (global_irq_enable_high_i && !wake_irq_low_i) begin
        state_d.vec_addr = `RTCF_VEC_IRQ_HI;
      end else if (global_irq_enable_low_i && wake_irq_low_i) begin
        state_d.vec_addr = `RTCF_VEC_IRQ_LO;
      end else begin
        state_d.vec_addr = pc_i + `RTCF_PC_STEP;
      end
    end
    // stack faults; underflow vectors to zero even without reset
    if (stack_full_i) begin
      state_d.stk[`RTCF_STK_FULL] = 1'b1;
      if (stk_rst_en) begin
        state_d.vec_load = 1'b1;
        state_d.vec_addr = `RTCF_VEC_RESET;
      end
    end
    if (stack_underflow_i) begin
      state_d.stk[`RTCF_STK_UNDER] = 1'b1;
      state_d.vec_load = 1'b1;
      state_d.vec_addr = `RTCF_VEC_RESET;
    end
    // real resets clear the stack pointer; wakes leave it
    if (reset_instr_i || brown_evt || ext_evt || (wdt_timeout_i && !wdt_wake) ||
        ((stack_full_i || stack_underflow_i) && stk_rst_en)) begin
      state_d.stk[`RTCF_STK_PTR_MSB:0] = '0;
    end

    // core held through time-outs, pin reset and brown-out
    state_d.hold = (state_d.seq != rtcf_pkg::rtcf_seq_done) ||
                   (pin_en && !external_reset_n_i) || brownout_i;

    // register reads, unimplemented bits as zero
    if (bus_i.re) begin
      if (bus_i.addr == `RTCF_ADDR_RESET_CAUSE_CONTROL) begin
        state_d.rdata = rd_masked(state_q.reset_cause_control, `RTCF_RC_RD_MASK);
        state_d.rdata[`RTCF_RC_SOFT_BO] = state_q.reset_cause_control[`RTCF_RC_SOFT_BO] && soft_bo_mode;
      end else if (bus_i.addr == `RTCF_ADDR_STK) begin
        state_d.rdata = rd_masked(state_q.stk, `RTCF_STK_RD_MASK);
      end else if (bus_i.addr == `RTCF_ADDR_CFG_BOPU) begin
        state_d.rdata = rd_masked(cfg_i.bopu, `RTCF_BOPU_MASK);
      end else if (bus_i.addr == `RTCF_ADDR_CFG_WDT) begin
        state_d.rdata = rd_masked(cfg_i.wdt, `RTCF_WDT_MASK);
      end else if (bus_i.addr == `RTCF_ADDR_CFG_PIN) begin
        state_d.rdata = rd_masked(cfg_i.pin, `RTCF_PIN_MASK);
      end else if (bus_i.addr == `RTCF_ADDR_CFG_DBG) begin
        state_d.rdata = rd_masked(cfg_i.dbg, `RTCF_DBG_MASK);
      end
    end
  end

  // ----------------------------------------------------------------
  // state register; power-on values
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_q <= '0;
      state_q.seq <= rtcf_pkg::rtcf_seq_start;
      state_q.reset_cause_control <= `RTCF_RC_RESET;
      state_q.osc_prev <= 1'b1;
      state_q.ext_prev <= 1'b1;
      state_q.hold <= 1'b1;
      state_q.vec_load <= 1'b1;
      state_q.vec_addr <= `RTCF_VEC_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs from the state register; soft brown-out enable also gated by the boen fuse field
  assign rdata_o = state_q.rdata;
  assign core_hold_o = state_q.hold;
  assign vec_load_o = state_q.vec_load;
  assign vec_addr_o = state_q.vec_addr;
  assign soft_brownout_enable_o = state_q.reset_cause_control[`RTCF_RC_SOFT_BO] && soft_bo_mode;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  // phase ends judged on the cycle that decides the next phase
  sequence s_pud_end;
    (state_q.seq == rtcf_pkg::rtcf_seq_pud) && crystal && !brownout_i ##1
      (state_q.seq != rtcf_pkg::rtcf_seq_pud);
  endsequence
  sequence s_settle_end;
    (state_q.seq == rtcf_pkg::rtcf_seq_settle) && with_pll && !brownout_i ##1
      (state_q.seq != rtcf_pkg::rtcf_seq_settle);
  endsequence

  a_hold_not_done: assert property ((state_q.seq != rtcf_pkg::rtcf_seq_done) |-> core_hold_o)
    else $error("core released before time-outs ended");
  a_settle_after_pud: assert property (s_pud_end |->
    state_q.seq == rtcf_pkg::rtcf_seq_settle)
    else $error("settle count did not follow power-up delay");
  a_pll_after_settle: assert property (s_settle_end |->
    state_q.seq == rtcf_pkg::rtcf_seq_pll)
    else $error("lock delay did not follow settle count");
  a_settle_count: assert property ((state_q.seq == rtcf_pkg::rtcf_seq_settle) && osc_rise &&
    (state_q.cnt < `RTCF_OST_LAST) && !brownout_i |=> state_q.seq == rtcf_pkg::rtcf_seq_settle)
    else $error("settle count ended early");
  a_rc_no_wait: assert property ((state_q.seq == rtcf_pkg::rtcf_seq_start) && !brownout_i &&
    !pud_en && !crystal |=> state_q.seq == rtcf_pkg::rtcf_seq_done)
    else $error("time-out applied without crystal or delay");
  a_instr_flag: assert property (reset_instr_i && !brown_evt |=>
    !state_q.reset_cause_control[`RTCF_RC_INSTR_N] && vec_load_o)
    else $error("reset instruction flag not cleared");
  a_wdt_sleep_wake: assert property (wdt_wake && !irq_wake && !stack_full_i &&
    !stack_underflow_i |=> vec_addr_o == $past(pc_i) + `RTCF_PC_STEP &&
    !state_q.reset_cause_control[`RTCF_RC_WDT_N] && !state_q.reset_cause_control[`RTCF_RC_PDOWN_N])
    else $error("watchdog wake wrong address or flags");
  a_ext_full_keep: assert property (ext_evt && (pm_mode_i == rtcf_pkg::rtcf_pm_full) &&
    !bus_i.we && !reset_instr_i && !brown_evt && !wdt_timeout_i && !wake_irq_i && !stack_full_i &&
    !stack_underflow_i |=> state_q.reset_cause_control == $past(state_q.reset_cause_control) &&
    state_q.stk[7:6] == $past(state_q.stk[7:6]))
    else $error("external reset at full power changed flags");
  a_rsv_zero: assert property ($past(bus_i.re) &&
    !($past(bus_i.addr) inside {`RTCF_ADDR_CFG_WDT, `RTCF_ADDR_CFG_PIN}) |-> rdata_o[5] == 1'b0)
    else $error("unimplemented bit read as one");
  a_pin_rsv_zero: assert property ($past(bus_i.re) &&
    ($past(bus_i.addr) == `RTCF_ADDR_CFG_PIN) |-> rdata_o[6] == 1'b0)
    else $error("unimplemented pin fuse bit read as one");
  a_por_state: assert property ($fell(srst_i) |-> core_hold_o &&
    state_q.reset_cause_control == `RTCF_RC_RESET && state_q.stk == 8'h00 && vec_addr_o == `RTCF_VEC_RESET)
    else $error("power-on state wrong");
  a_ext_sleep_flags: assert property (ext_evt && !wdt_timeout_i && !irq_wake &&
    ((pm_mode_i == rtcf_pkg::rtcf_pm_idle) || (pm_mode_i == rtcf_pkg::rtcf_pm_sleep)) |=>
    state_q.reset_cause_control[`RTCF_RC_WDT_N] && !state_q.reset_cause_control[`RTCF_RC_PDOWN_N] && vec_load_o)
    else $error("external reset in sleep set wrong flags");
  a_wdt_run_reset: assert property (wdt_timeout_i && !wdt_wake && !irq_wake &&
    !stack_full_i && !stack_underflow_i |=> !state_q.reset_cause_control[`RTCF_RC_WDT_N] &&
    vec_load_o && vec_addr_o == `RTCF_VEC_RESET)
    else $error("watchdog reset wrong flag or vector");
  a_irq_high_vec: assert property (irq_wake && global_irq_enable_high_i &&
    !wake_irq_low_i && !stack_full_i && !stack_underflow_i |=>
    vec_addr_o == `RTCF_VEC_IRQ_HI && !state_q.reset_cause_control[`RTCF_RC_PDOWN_N])
    else $error("interrupt wake wrong vector or flag");
  a_stk_full_flag: assert property (stack_full_i |=> state_q.stk[`RTCF_STK_FULL])
    else $error("stack full flag not set");
  a_unf_vector: assert property (stack_underflow_i |=> vec_load_o &&
    vec_addr_o == `RTCF_VEC_RESET && state_q.stk[`RTCF_STK_UNDER])
    else $error("underflow did not vector to zero");
  a_brown_flags: assert property (brown_evt && !bus_i.we |=>
    state_q.reset_cause_control[`RTCF_RC_INSTR_N] && !state_q.reset_cause_control[`RTCF_RC_BROWN_N] &&
    $stable(state_q.reset_cause_control[`RTCF_RC_PWRON_N]))
    else $error("brown-out set wrong flags");
  a_soft_bo_keep: assert property (!bus_i.we && (brown_evt || ext_evt ||
    reset_instr_i || wdt_timeout_i) |=> $stable(soft_brownout_enable_o))
    else $error("soft brown-out enable changed on a reset");
  a_pin_holds: assert property (pin_en && !external_reset_n_i |=> core_hold_o)
    else $error("core ran while reset pin low");
  a_pin_release: assert property ((state_q.seq == rtcf_pkg::rtcf_seq_done) &&
    !brownout_i && !pm_exit_osc_stopped_i && (!pin_en || external_reset_n_i) |=> !core_hold_o)
    else $error("core held after all time-outs");

endmodule
`default_nettype wire

/* File: dv/rtcf_pin_model.sv */
// partner model: crystal on the oscillator pin, external reset pin
// assumes the bench clock; pins change just after rising edges
`timescale 1ns/1ns
`default_nettype none

module rtcf_pin_model (
  // bench control
  input wire logic clk_i,
  input wire logic osc_run_i,
  input wire logic pin_low_i,
  // pins toward the block
  output logic oscillator_input_pin_o,
  output logic external_reset_n_o
);
  // crystal toggles each cycle while powered, held low otherwise
  always @(posedge clk_i) begin
    if (osc_run_i) begin
      oscillator_input_pin_o <= ~oscillator_input_pin_o;
    end else begin
      oscillator_input_pin_o <= 1'b0;
    end
  end
  // pin has a pull-up, so a released pin reads high
  assign external_reset_n_o = ~pin_low_i;
endmodule

`default_nettype wire

/* File: dv/tb_reset_timeout_and_cause_flags.sv */
// self-checking bench for the reset time-out and reset-cause block
// assumes rtcf_pkg, rtcf_top and rtcf_pin_model are compiled first
`timescale 1ns/1ns
`default_nettype none

module tb_reset_timeout_and_cause_flags;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam int PW = 20;
  localparam int PL = 10;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  rtcf_pkg::rtcf_bus_t bus = '0;
  rtcf_pkg::rtcf_cfg_t cfg = '{bopu: 8'h03, wdt: 8'hFF, pin: 8'hFF, dbg: 8'hFF};
  rtcf_pkg::rtcf_osc_t osc = rtcf_pkg::rtcf_osc_resistor_capacitor_osc;
  rtcf_pkg::rtcf_pm_t pm = rtcf_pkg::rtcf_pm_full;
  logic osc_run = 1'b0, pin_low = 1'b0, brown = 1'b0, pm_exit = 1'b0, rinstr = 1'b0;
  logic wdt = 1'b0, irq = 1'b0, irq_low = 1'b0, gie_h = 1'b0, gie_l = 1'b0;
  logic stk_full = 1'b0, stk_unf = 1'b0;
  logic [20:0] pc = 21'h000100;
  logic osc_pin, rst_n, hold, vload, sbo;
  logic [7:0] rdata;
  logic [20:0] vaddr;
  int n_fail = 0;
  int checks = 0;
  int n;

  rtcf_top #(.POWER_UP_DELAY_TIMER_CYCLES(PW), .PLL_CYCLES(PL)) i_rtcf_top (
    .clk_i(clk_i), .srst_i(srst_i), .bus_i(bus), .rdata_o(rdata), .cfg_i(cfg),
    .osc_mode_i(osc), .oscillator_input_pin_i(osc_pin), .external_reset_n_i(rst_n),
    .brownout_i(brown), .pm_mode_i(pm), .pm_exit_osc_stopped_i(pm_exit),
    .reset_instr_i(rinstr), .wdt_timeout_i(wdt), .wake_irq_i(irq), .wake_irq_low_i(irq_low),
    .global_irq_enable_high_i(gie_h), .global_irq_enable_low_i(gie_l),
    .stack_full_i(stk_full), .stack_underflow_i(stk_unf), .pc_i(pc), .core_hold_o(hold),
    .vec_load_o(vload), .vec_addr_o(vaddr), .soft_brownout_enable_o(sbo)
  );

  rtcf_pin_model i_rtcf_pin_model (
    .clk_i(clk_i), .osc_run_i(osc_run), .pin_low_i(pin_low),
    .oscillator_input_pin_o(osc_pin), .external_reset_n_o(rst_n)
  );

  // 100 MHz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", n_fail, checks);
    if (n_fail == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chkv(input logic [20:0] got, input logic [20:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chkr(input int got, input int lo, input int hi, input string what);
    checks++;
    if (got < lo || got > hi) begin
      n_fail++;
      $display("MISMATCH %0t %s got %0d exp %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  task automatic stuck(input string what);
    n_fail++;
    $display("MISMATCH %0t wait ran out: %s", $time, what);
    close_out();
  endtask

  // counts cycles until the core is let go
  task automatic wait_free(input int bound, output int c);
    c = 0;
    #1;
    while (hold !== 1'b0) begin
      @(posedge clk_i);
      #1;
      c++;
      if (c > bound) begin
        stuck("core held");
      end
    end
  endtask

  // ----------------------------------------------------------------
  // register port and reset
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge clk_i);
    bus <= '0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    bus <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge clk_i);
    bus <= '0;
    #1;
    chkv(rdata, exp, "read");
  endtask

  // power-on pulse of ten cycles; crystal starts with the release
  task automatic por(input logic [3:0] o, input logic [7:0] b);
    @(posedge clk_i);
    srst_i <= 1'b1;
    osc_run <= 1'b0;
    osc <= rtcf_pkg::rtcf_osc_t'(o);
    cfg.bopu <= b;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    osc_run <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic reset_values();
    por(4'h6, 8'h03);
    #1;
    chkv(vaddr, 21'h0, "vec");
    wait_free(40, n);
    rdc(8'h00, 8'h5C);
    rdc(8'h01, 8'h00);
    rdc(8'h03, 8'h3F);
    rdc(8'h04, 8'hBF);
    rdc(8'h05, 8'hC5);
    rdc(8'h3A, 8'h00);
    wr(8'h02, 8'h00);
    rdc(8'h02, 8'h03);
    wr(8'h00, 8'hFF);
    rdc(8'h00, 8'hDF);
  endtask

  // mode codes: 0 low-power, 1 standard, 2 high-speed, 3 pll crystal,
  // 4 ext clock, 5 ext clock io, 6 rc, 7 rc io, 8 int clkout, 9 int io
  task automatic seq_table();
    logic [3:0] m [11] = '{1, 2, 0, 3, 3, 4, 6, 9, 7, 5, 8};
    logic [7:0] b [11] = '{2, 3, 2, 2, 3, 2, 3, 3, 2, 3, 2};
    int lo [11] = '{PW + 2046, 2046, PW + 2046, PW + PL + 2046, PL + 2046, PW, 0, 0, PW, 0, PW};
    for (int i = 0; i < 11; i++) begin
      por(m[i], b[i]);
      wait_free(3000, n);
      chkr(n, lo[i], lo[i] + 10, "cyc");
    end
  endtask

  // wake from a mode that stopped the oscillator
  task automatic exit_case();
    logic [3:0] m [3] = '{1, 3, 6};
    int lo [3] = '{2040, 2040 + PL, 0};
    for (int i = 0; i < 3; i++) begin
      por(m[i], 8'h03);
      wait_free(3000, n);
      @(posedge clk_i);
      pm_exit <= 1'b1;
      @(posedge clk_i);
      pm_exit <= 1'b0;
      @(posedge clk_i);
      wait_free(3000, n);
      chkr(n, lo[i], lo[i] + 16, "wake cyc");
    end
  endtask

  // pin held low past every time-out, then released
  task automatic pin_early();
    pin_low <= 1'b1;
    por(4'h1, 8'h02);
    repeat (2200) @(posedge clk_i);
    #1;
    chkv(hold, 1'b1, "held");
    @(posedge clk_i);
    pin_low <= 1'b0;
    wait_free(4, n);
    chkr(n, 1, 2, "release cyc");
  endtask

  // one event pulse, then vector and one register
  task automatic ev(input logic [6:0] k, input logic [1:0] p, input logic [20:0] vec,
                    input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    pm <= rtcf_pkg::rtcf_pm_t'(p);
    {rinstr, brown, pin_low, wdt, irq, stk_full, stk_unf} <= k;
    @(posedge clk_i);
    {rinstr, brown, pin_low, wdt, irq, stk_full, stk_unf} <= 7'h00;
    n = 0;
    #1;
    while (vload !== 1'b1) begin
      @(posedge clk_i);
      #1;
      n++;
      if (n > 4) begin
        stuck("vector load");
      end
    end
    chkv(vaddr, vec, "vec");
    wait_free(40, n);
    rdc(a, exp);
  endtask

  // pm codes: 0 full, 1 run, 2 idle, 3 sleep
  task automatic events();
    por(4'h6, 8'h03);
    wait_free(40, n);
    ev(7'h08, 2'h3, 21'h102, 8'h00, 8'h50);
    ev(7'h10, 2'h3, 21'h0, 8'h00, 8'h58);
    ev(7'h08, 2'h1, 21'h0, 8'h00, 8'h50);
    ev(7'h10, 2'h1, 21'h0, 8'h00, 8'h58);
    ev(7'h08, 2'h0, 21'h0, 8'h00, 8'h50);
    ev(7'h10, 2'h0, 21'h0, 8'h00, 8'h50);
    ev(7'h40, 2'h0, 21'h0, 8'h00, 8'h40);
    wr(8'h00, 8'h03);
    ev(7'h20, 2'h0, 21'h0, 8'h00, 8'h1E);
    ev(7'h04, 2'h3, 21'h102, 8'h00, 8'h1A);
    gie_h <= 1'b1;
    ev(7'h04, 2'h2, 21'h008, 8'h00, 8'h1A);
    irq_low <= 1'b1;
    gie_l <= 1'b1;
    ev(7'h04, 2'h3, 21'h018, 8'h00, 8'h1A);
    ev(7'h02, 2'h0, 21'h0, 8'h01, 8'h80);
    ev(7'h01, 2'h0, 21'h0, 8'h01, 8'hC0);
    wr(8'h01, 8'h00);
    cfg.dbg <= 8'hFE;
    ev(7'h01, 2'h0, 21'h0, 8'h01, 8'h40);
  endtask

  task automatic soft_bo();
    por(4'h6, 8'h01);
    wait_free(40, n);
    rdc(8'h00, 8'h1C);
    chkv(sbo, 1'b0, "soft enable");
    por(4'h6, 8'h03);
    wait_free(40, n);
    chkv(sbo, 1'b1, "soft enable");
  endtask

  // main sequence
  initial begin
    reset_values();
    seq_table();
    exit_case();
    pin_early();
    events();
    soft_bo();
    close_out();
  end
endmodule

`default_nettype wire
